// *** phy_np_regs.sv ***
// Contract
// - Message-page bit writable, resets to one
// - Comply flag writable, resets to zero
// - Local toggle read-only, previous transmitted toggle
// - Eleven-bit writable message field, resets one
// - Partner next-page bit read-only, resets zero
// - Partner acknowledge bit read-only
// - Partner comply flag read-only
// - Partner toggle reads inverse of previous
// - Function 01 data access, address held
// - Function 10 increments after reads, writes
// - Function 11 increments after writes only
// - Data access uses selected device's address
// - PLL-off bit gates PLL during power down
// - PLL-off only effective with energy-detect power down
module phy_np_regs (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic [phy_np_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [phy_np_pkg::DATA_W-1:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [phy_np_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [phy_np_pkg::DATA_W-1:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire phy_np_pkg::partner_page_t partner_page_i,
    input wire logic partner_page_load_i,
    input wire logic tx_toggle_i,
    input wire logic energy_detect_power_down_i,
    output phy_np_pkg::local_page_t local_page_o,
    output logic pll_off_o
);
    import phy_np_pkg::*;

    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_EXEC = 3'b010,
        WR_RESP = 3'b100
    } wr_state_t;

    logic [ADDR_W-1:0] aw_addr;
    logic aw_have;
    logic [REG_W-1:0] w_data;
    logic [1:0] w_strb;
    logic w_have;
    wr_state_t wr_state;

    logic msg_page;
    logic comply_flag;
    logic [NP_MSG_MSB:0] message;
    logic local_toggle;
    partner_page_t partner;
    logic [1:0] func;
    logic [IC_DEV_MSB:0] dev_sel;
    logic pll_off_en;
    logic [REG_W-1:0] afe_ctrl0;
    logic [REG_W-1:0] ext_addr [NUM_DEV];
    logic [REG_W-1:0] ext_mem [NUM_DEV][EXT_DEPTH];

    logic wr_fire;
    logic rd_fire;
    logic [5:0] wr_idx;
    logic [5:0] rd_idx;
    logic [REG_W-1:0] wr_val;
    logic [REG_W-1:0] wr_old;
    logic [REG_W-1:0] rd_val;
    logic rd_ok;
    logic wr_ok;
    logic [REG_W-1:0] sel_addr;

    assign wr_idx = aw_addr[ADDR_W-1:2];
    assign rd_idx = s_axi_araddr_i[ADDR_W-1:2];
    assign wr_fire = (wr_state == WR_EXEC);
    assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;
    assign sel_addr = ext_addr[dev_sel];

    // Unwritten lanes keep the value that the register shows at the moment of the write.
    always_comb begin
        wr_old = rd_val_at(wr_idx);
    end

    // Only the low two lanes carry register bits; the upper lanes are dropped.
    always_comb begin
        wr_val = wr_old;
        wr_val[7:0] = w_strb[0] ? w_data[7:0] : wr_old[7:0];
        wr_val[15:8] = w_strb[1] ? w_data[15:8] : wr_old[15:8];
    end

    function automatic logic [REG_W-1:0] rd_val_at(input logic [5:0] idx);
        logic [REG_W-1:0] v;
        v = 16'h0000;
        unique case (idx)
            IDX_LOCAL_NP: begin
                v[NP_MSG_PAGE_BIT] = msg_page;
                v[NP_COMPLY_BIT] = comply_flag;
                v[NP_TOGGLE_BIT] = local_toggle;
                v[NP_MSG_MSB:0] = message;
            end
            IDX_PARTNER_NP: v = partner;
            IDX_IND_CTRL: begin
                v[REG_W-1:IC_FUNC_LSB] = func;
                v[IC_DEV_MSB:0] = dev_sel;
            end
            IDX_IND_ADDR_DATA: begin
                if (func == FUNC_ADDR) begin
                    v = sel_addr;
                end else begin
                    v = ext_mem[dev_sel][sel_addr[EXT_AW-1:0]];
                end
            end
            IDX_DIG_CTRL: v[DC_PLL_OFF_BIT] = pll_off_en;
            IDX_AFE_CTRL0: v = afe_ctrl0;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    function automatic logic idx_ok(input logic [5:0] idx);
        return idx == IDX_LOCAL_NP || idx == IDX_PARTNER_NP || idx == IDX_IND_CTRL
            || idx == IDX_IND_ADDR_DATA || idx == IDX_DIG_CTRL || idx == IDX_AFE_CTRL0;
    endfunction

    // A process rather than an assign, so that it wakes on every register the function reads.
    always_comb begin
        rd_val = rd_val_at(rd_idx);
    end
    assign rd_ok = idx_ok(rd_idx);
    assign wr_ok = idx_ok(wr_idx);

    // Write channel: address and data are taken in either order, then one execute cycle.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            aw_have <= 1'b0;
            aw_addr <= '0;
            s_axi_awready_o <= 1'b0;
        end else begin
            s_axi_awready_o <= !aw_have && !s_axi_awready_o && wr_state == WR_IDLE;
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_have <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
            end else if (wr_fire) begin
                aw_have <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            w_have <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_wready_o <= 1'b0;
        end else begin
            s_axi_wready_o <= !w_have && !s_axi_wready_o && wr_state == WR_IDLE;
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_have <= 1'b1;
                w_data <= s_axi_wdata_i[REG_W-1:0];
                w_strb <= s_axi_wstrb_i[1:0];
            end else if (wr_fire) begin
                w_have <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            wr_state <= WR_IDLE;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
        end else begin
            unique case (wr_state)
                WR_IDLE: begin
                    if (aw_have && w_have) begin
                        wr_state <= WR_EXEC;
                    end
                end
                WR_EXEC: begin
                    wr_state <= WR_RESP;
                    s_axi_bvalid_o <= 1'b1;
                    s_axi_bresp_o <= wr_ok ? RESP_OKAY : RESP_SLVERR;
                end
                WR_RESP: begin
                    if (s_axi_bready_i) begin
                        s_axi_bvalid_o <= 1'b0;
                        wr_state <= WR_IDLE;
                    end
                end
            endcase
        end
    end

    // Read channel: one read at a time, data answered the cycle after the address is taken.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= '0;
            s_axi_rresp_o <= RESP_OKAY;
        end else begin
            s_axi_arready_o <= !s_axi_arready_o && !s_axi_rvalid_o && !s_axi_arvalid_i ? 1'b1
                : (s_axi_arready_o ? 1'b0 : !s_axi_rvalid_o);
            if (rd_fire) begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= {16'h0000, rd_val};
                s_axi_rresp_o <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid_o && s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end

    // Local next-page fields.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            msg_page <= NP_MSG_PAGE_RST;
            comply_flag <= NP_COMPLY_RST;
            message <= NP_MSG_RST;
        end else if (wr_fire && wr_idx == IDX_LOCAL_NP) begin
            msg_page <= wr_val[NP_MSG_PAGE_BIT];
            comply_flag <= wr_val[NP_COMPLY_BIT];
            message <= wr_val[NP_MSG_MSB:0];
        end
    end

    // The toggle follows the link; software writes to it are dropped.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            local_toggle <= 1'b0;
        end else begin
            local_toggle <= tx_toggle_i;
        end
    end

    // Partner page is captured whole on a received page so fields never mix two pages.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            partner <= '0;
        end else if (partner_page_load_i) begin
            partner.next_page <= partner_page_i.next_page;
            partner.ack <= partner_page_i.ack;
            partner.msg_page <= partner_page_i.msg_page;
            partner.comply_flag <= partner_page_i.comply_flag;
            partner.toggle <= !partner_page_i.toggle;
            partner.message <= partner_page_i.message;
        end
    end

    // Reserved control bits are not stored, so they read zero whatever was written.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            func <= FUNC_ADDR;
            dev_sel <= '0;
        end else if (wr_fire && wr_idx == IDX_IND_CTRL) begin
            func <= wr_val[REG_W-1:IC_FUNC_LSB];
            dev_sel <= wr_val[IC_DEV_MSB:0];
        end
    end

    // Per-device address pointers; increment is applied as the access completes.
    generate
        for (genvar d = 0; d < NUM_DEV; d++) begin : g_dev
            localparam logic [IC_DEV_MSB:0] DEV_ID = (IC_DEV_MSB + 1)'(d);
            logic hit;
            logic is_wr;
            logic is_rd;
            logic wr_step;
            logic rd_step;
            logic [REG_W-1:0] next_addr;
            assign hit = dev_sel == DEV_ID;
            assign is_wr = wr_fire && wr_idx == IDX_IND_ADDR_DATA && hit;
            assign is_rd = rd_fire && rd_idx == IDX_IND_ADDR_DATA && hit;
            assign wr_step = is_wr && func != FUNC_ADDR && func != FUNC_DATA;
            assign rd_step = is_rd && func == FUNC_DATA_INC_RW;
            // A read and a write may complete together; each advances the pointer once.
            always_comb begin
                if (is_wr && func == FUNC_ADDR) begin
                    next_addr = wr_val;
                end else begin
                    next_addr = ext_addr[d] + REG_W'(wr_step) + REG_W'(rd_step);
                end
            end
            always_ff @(posedge core_clk_i) begin
                if (srst_i) begin
                    ext_addr[d] <= '0;
                end else begin
                    ext_addr[d] <= next_addr;
                end
            end
            always_ff @(posedge core_clk_i) begin
                if (srst_i) begin
                    ext_mem[d] <= '{default: '0};
                end else if (is_wr && func != FUNC_ADDR) begin
                    ext_mem[d][ext_addr[d][EXT_AW-1:0]] <= wr_val;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pll_off_en <= 1'b0;
        end else if (wr_fire && wr_idx == IDX_DIG_CTRL) begin
            pll_off_en <= wr_val[DC_PLL_OFF_BIT];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            afe_ctrl0 <= '0;
        end else if (wr_fire && wr_idx == IDX_AFE_CTRL0) begin
            afe_ctrl0 <= wr_val;
        end
    end

    // The PLL may only stop while power down is in force; otherwise it keeps running.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pll_off_o <= 1'b0;
        end else begin
            pll_off_o <= pll_off_en && energy_detect_power_down_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            local_page_o <= '0;
        end else begin
            local_page_o <= '{msg_page: msg_page, comply_flag: comply_flag, message: message};
        end
    end

endmodule

// *** phy_np_pkg.sv ***
package phy_np_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;

    // Printed offsets are register indices; byte address is four times the index.
    localparam logic [5:0] IDX_LOCAL_NP = 6'h07;
    localparam logic [5:0] IDX_PARTNER_NP = 6'h08;
    localparam logic [5:0] IDX_IND_CTRL = 6'h0D;
    localparam logic [5:0] IDX_IND_ADDR_DATA = 6'h0E;
    localparam logic [5:0] IDX_DIG_CTRL = 6'h10;
    localparam logic [5:0] IDX_AFE_CTRL0 = 6'h11;

    // Local next-page fields.
    localparam int NP_MSG_PAGE_BIT = 13;
    localparam int NP_COMPLY_BIT = 12;
    localparam int NP_TOGGLE_BIT = 11;
    localparam int NP_MSG_MSB = 10;
    localparam logic NP_MSG_PAGE_RST = 1'b1;
    localparam logic NP_COMPLY_RST = 1'b0;
    localparam logic [10:0] NP_MSG_RST = 11'h001;

    // Partner next-page fields.
    localparam int LP_NEXT_BIT = 15;
    localparam int LP_ACK_BIT = 14;
    localparam int LP_MSG_PAGE_BIT = 13;

    // Indirect access control fields.
    localparam int IC_FUNC_LSB = 14;
    localparam int IC_DEV_MSB = 4;
    localparam logic [1:0] FUNC_ADDR = 2'h0;
    localparam logic [1:0] FUNC_DATA = 2'h1;
    localparam logic [1:0] FUNC_DATA_INC_RW = 2'h2;
    localparam logic [1:0] FUNC_DATA_INC_W = 2'h3;

    localparam int DC_PLL_OFF_BIT = 4;

    localparam int NUM_DEV = 32;
    localparam int EXT_DEPTH = 16;
    localparam int EXT_AW = 4;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic next_page;
        logic ack;
        logic msg_page;
        logic comply_flag;
        logic toggle;
        logic [10:0] message;
    } partner_page_t;

    typedef struct packed {
        logic msg_page;
        logic comply_flag;
        logic [10:0] message;
    } local_page_t;

endpackage

// *** phy_np_props.sv ***
module phy_np_props (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [phy_np_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [phy_np_pkg::DATA_W-1:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic energy_detect_power_down_i,
    input wire phy_np_pkg::local_page_t local_page_o,
    input wire logic pll_off_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import phy_np_pkg::*;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    sequence wr_taken;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    sequence rd_taken;
        s_axi_arvalid_i && s_axi_arready_o;
    endsequence
    sequence rst_release;
        srst_i ##1 !srst_i;
    endsequence
    wr_resp_time_a: assert property (wr_taken |-> ##3 s_axi_bvalid_o)
        else $error("write response late or early");
    rd_resp_time_a: assert property (rd_taken |=> s_axi_rvalid_o)
        else $error("read data not one cycle after address");
    rd_data_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
        s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
    wr_resp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
        else $error("write response dropped");
    rd_busy_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read address accepted while busy");
    unmapped_rd_a: assert property (rd_taken and s_axi_araddr_i == 8'h00 |=>
        s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0) else $error("bad unmapped read");
    pll_gate_a: assert property (pll_off_o |-> $past(energy_detect_power_down_i))
        else $error("pll off outside power down");
    pll_reset_a: assert property (disable iff (1'b0) srst_i |=> !pll_off_o)
        else $error("pll off after reset");
    page_reset_a: assert property (disable iff (1'b0) rst_release |=>
        local_page_o == {NP_MSG_PAGE_RST, NP_COMPLY_RST, NP_MSG_RST})
        else $error("local page reset value wrong");
endmodule

bind phy_np_regs phy_np_props u_props (.core_clk_i, .srst_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .energy_detect_power_down_i, .local_page_o, .pll_off_o);

// *** axi_host.sv ***
module axi_host (
    input wire logic core_clk_i,
    output logic [phy_np_pkg::ADDR_W-1:0] aw_addr_o,
    output logic aw_valid_o,
    input wire logic aw_ready_i,
    output logic [phy_np_pkg::DATA_W-1:0] w_data_o,
    output logic [3:0] w_strb_o,
    output logic w_valid_o,
    input wire logic w_ready_i,
    input wire logic [1:0] b_resp_i,
    input wire logic b_valid_i,
    output logic b_ready_o,
    output logic [phy_np_pkg::ADDR_W-1:0] ar_addr_o,
    output logic ar_valid_o,
    input wire logic ar_ready_i,
    input wire logic [phy_np_pkg::DATA_W-1:0] r_data_i,
    input wire logic [1:0] r_resp_i,
    input wire logic r_valid_i,
    output logic r_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import phy_np_pkg::*;
    int timeouts;
    initial begin
        {aw_valid_o, w_valid_o, b_ready_o, ar_valid_o, r_ready_o} = 5'h00;
        aw_addr_o = 8'h00;
        ar_addr_o = 8'h00;
        w_data_o = 32'h0;
        w_strb_o = 4'hF;
        timeouts = 0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        int n;
        if (a == {IDX_IND_CTRL, 2'h0}) d = d & 32'h0000_C01F;
        aw_addr_o <= a;
        w_data_o <= d;
        aw_valid_o <= 1'b1;
        w_valid_o <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk_i);
            if (aw_ready_i) aw_valid_o <= 1'b0;
            if (w_ready_i) w_valid_o <= 1'b0;
            n++;
        end while (((aw_valid_o && !aw_ready_i) || (w_valid_o && !w_ready_i)) && n < 100);
        // Response ready is held back a cycle so the slave must keep its answer standing.
        while (!b_valid_i && n < 100) begin
            @(posedge core_clk_i);
            n++;
        end
        b_ready_o <= 1'b1;
        @(posedge core_clk_i);
        resp = b_resp_i;
        b_ready_o <= 1'b0;
        if (n >= 100) timeouts++;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        ar_addr_o <= a;
        ar_valid_o <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (!ar_ready_i && n < 100);
        ar_valid_o <= 1'b0;
        while (!r_valid_i && n < 100) begin
            @(posedge core_clk_i);
            n++;
        end
        r_ready_o <= 1'b1;
        @(posedge core_clk_i);
        d = r_data_i;
        resp = r_resp_i;
        r_ready_o <= 1'b0;
        if (n >= 100) timeouts++;
    endtask
endmodule

// *** tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import phy_np_pkg::*;
    logic core_clk_i, srst_i, tx_toggle_i, energy_detect_power_down_i, partner_page_load_i;
    logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
    logic s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
    logic [ADDR_W-1:0] s_axi_awaddr_i, s_axi_araddr_i;
    logic [DATA_W-1:0] s_axi_wdata_i, s_axi_rdata_o;
    logic [3:0] s_axi_wstrb_i;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    partner_page_t partner_page_i;
    local_page_t local_page_o;
    logic pll_off_o;
    int num_errors, n_checks;
    phy_np_regs dut (.core_clk_i, .srst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
        .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
        .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .partner_page_i,
        .partner_page_load_i, .tx_toggle_i, .energy_detect_power_down_i, .local_page_o, .pll_off_o);
    axi_host host (.core_clk_i, .aw_addr_o(s_axi_awaddr_i), .aw_valid_o(s_axi_awvalid_i),
        .aw_ready_i(s_axi_awready_o), .w_data_o(s_axi_wdata_i), .w_strb_o(s_axi_wstrb_i),
        .w_valid_o(s_axi_wvalid_i), .w_ready_i(s_axi_wready_o), .b_resp_i(s_axi_bresp_o),
        .b_valid_i(s_axi_bvalid_o), .b_ready_o(s_axi_bready_i), .ar_addr_o(s_axi_araddr_i),
        .ar_valid_o(s_axi_arvalid_i), .ar_ready_i(s_axi_arready_o), .r_data_i(s_axi_rdata_o),
        .r_resp_i(s_axi_rresp_o), .r_valid_i(s_axi_rvalid_o), .r_ready_o(s_axi_rready_i));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        host.wr(a, d, r);
        check($sformatf("write resp %h", a), {30'h0, RESP_OKAY}, {30'h0, r});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        host.rd(a, d, r);
        check($sformatf("read %h", a), exp, d);
    endtask
    task automatic load_page(input logic [15:0] w);
        @(posedge core_clk_i);
        partner_page_i <= w;
        partner_page_load_i <= 1'b1;
        @(posedge core_clk_i);
        partner_page_load_i <= 1'b0;
        // Once captured the word no longer stands, so a late capture would see garbage.
        partner_page_i <= ~w;
    endtask
    task automatic t_reset();
        rd(8'h1C, 32'h0000_2001);
        rd(8'h20, 32'h0000_0000);
        rd(8'h34, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        $display("test reset_values done");
    endtask
    task automatic t_local();
        wr(8'h1C, 32'h0000_1555);
        rd(8'h1C, 32'h0000_1555);
        check("local page", 32'h0000_0D55, {19'h0, local_page_o});
        tx_toggle_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        rd(8'h1C, 32'h0000_1D55);
        $display("test local_page done");
    endtask
    task automatic t_partner();
        logic [1:0] r;
        load_page(16'hD2AA);
        rd(8'h20, 32'h0000_DAAA);
        host.wr(8'h20, 32'h0000_0000, r);
        rd(8'h20, 32'h0000_DAAA);
        load_page(16'h0800);
        rd(8'h20, 32'h0000_0000);
        $display("test partner_page done");
    endtask
    task automatic t_indirect();
        wr(8'h34, 32'h0000_0003);
        wr(8'h38, 32'h0000_0005);
        rd(8'h34, 32'h0000_0003);
        wr(8'h34, 32'h0000_DFE3);
        wr(8'h38, 32'h0000_1111);
        wr(8'h38, 32'h0000_2222);
        wr(8'h34, 32'h0000_0003);
        rd(8'h38, 32'h0000_0007);
        wr(8'h38, 32'h0000_0006);
        wr(8'h34, 32'h0000_C003);
        rd(8'h38, 32'h0000_2222);
        rd(8'h38, 32'h0000_2222);
        wr(8'h34, 32'h0000_4003);
        wr(8'h38, 32'h0000_3333);
        rd(8'h38, 32'h0000_3333);
        wr(8'h34, 32'h0000_0003);
        rd(8'h38, 32'h0000_0006);
        wr(8'h38, 32'h0000_0005);
        wr(8'h34, 32'h0000_8003);
        rd(8'h38, 32'h0000_1111);
        rd(8'h38, 32'h0000_3333);
        wr(8'h38, 32'h0000_4444);
        wr(8'h34, 32'h0000_0003);
        rd(8'h38, 32'h0000_0008);
        wr(8'h34, 32'h0000_0004);
        rd(8'h38, 32'h0000_0000);
        $display("test indirect_access done");
    endtask
    task automatic t_pll();
        logic [31:0] d;
        logic [1:0] r;
        wr(8'h40, 32'h0000_0010);
        rd(8'h40, 32'h0000_0010);
        check("pll off idle", 32'h0, {31'h0, pll_off_o});
        energy_detect_power_down_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        check("pll off power down", 32'h1, {31'h0, pll_off_o});
        wr(8'h40, 32'h0000_0000);
        check("pll on power down", 32'h0, {31'h0, pll_off_o});
        energy_detect_power_down_i <= 1'b0;
        host.rd(8'h00, d, r);
        check("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        check("unmapped data", 32'h0, d);
        wr(8'h44, 32'h0000_ABCD);
        rd(8'h44, 32'h0000_ABCD);
        $display("test pll_and_unmapped done");
    endtask
    task automatic end_of_test();
        check("host waits", 32'h0, host.timeouts);
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    initial begin
        srst_i = 1'b1;
        tx_toggle_i = 1'b0;
        energy_detect_power_down_i = 1'b0;
        partner_page_load_i = 1'b0;
        partner_page_i = 16'h0000;
        repeat (12) @(posedge core_clk_i);
        srst_i <= 1'b0;
        @(posedge core_clk_i);
        t_reset();
        t_local();
        t_partner();
        t_indirect();
        t_pll();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge core_clk_i);
        num_errors++;
        $display("[FAIL] run length expected finish seen hang");
        end_of_test();
    end
endmodule
